// >>> hdl/mcis_pkg.sv
// constants for the monitor configuration and interrupt status block
package mcis_pkg;

    // register offsets
    localparam logic [7:0] CFG_ADDR   = 8'h00;
    localparam logic [7:0] VSTAT_ADDR = 8'h01;
    localparam logic [7:0] TSTAT_ADDR = 8'h02;
    localparam logic [7:0] VMASK_ADDR = 8'h03;
    localparam logic [7:0] TMASK_ADDR = 8'h04;

    // reset values
    localparam logic [7:0] CFG_RST   = 8'h08;
    localparam logic [7:0] VSTAT_RST = 8'h00;
    localparam logic [7:0] TSTAT_RST = 8'h00;
    localparam logic [7:0] VMASK_RST = 8'h00;
    localparam logic [7:0] TMASK_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

    // configuration bit positions
    localparam int CFG_START    = 0;
    localparam int CFG_INT_EN   = 1;
    localparam int CFG_INT_POL  = 2;
    localparam int CFG_SUPPRESS = 3;
    localparam int CFG_RSTPULSE = 4;
    localparam int CFG_CHCLEAR  = 5;
    localparam int CFG_GPDRIVE  = 6;
    localparam int CFG_SOFTDEF  = 7;

    // thermal/fan status bit positions, and the voltage status external-interrupt bit
    localparam int TS_HOT      = 0;
    localparam int TS_BOARD    = 1;
    localparam int TS_TACH1    = 2;
    localparam int TS_TACH2    = 3;
    localparam int TS_INTRUDE  = 4;
    localparam int TS_OVERTEMP = 5;
    localparam int VS_EXTINT   = 7;

    // mask 2 mode-select positions and implemented status bits
    localparam int TM_HOT_MODE = 6;
    localparam int TM_OT_MODE  = 7;
    localparam logic [7:0] TSTAT_USED = 8'h3F;

    // timing
    localparam int CLK_HZ       = 20_000_000;
    localparam int PULSE_MS     = 10;
    localparam int PULSE_CYCLES = (CLK_HZ / 1000) * PULSE_MS;
    localparam int CNT_W        = 18;

endpackage

// >>> hdl/mcis_sync.sv
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module mcis_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic resetn_i,
    // pin and clean level
    input  wire logic pin_i,
    output logic      level_o
);

    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       level_reg;
    logic       level_next;

    always_comb begin
        stage_next = {stage_reg[1:0], pin_i};
        level_next = level_reg;
        if (stage_reg[2] == stage_reg[1]) begin
            level_next = stage_reg[2];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            stage_reg <= {3{RST_VAL}};
            level_reg <= RST_VAL;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;

endmodule
`default_nettype wire

// >>> hdl/mcis_top.sv
// configuration, event status, masks and interrupt pin of the monitor
// Notes on behaviour
// [R01] start bit one runs monitoring, zero shuts down
// [R02] clearing start keeps interrupt pin asserted
// [R03] host loads limits before setting start
// [R04] interrupt pin works only when enabled
// [R05] polarity bit: high open-source or low open-drain
// [R06] suppress bit releases pin, halts monitoring
// [R07] reset bit gives 10 ms low pulse
// [R08] chassis clear clears intrusion latch, 10 ms
// [R09] drive bit pulls general pin low
// [R10] soft defaults bit restores defaults, self-clears
// [R11] configuration resets to 08h
// [R12] voltage channel out of limits sets status
// [R13] low on external interrupt input sets bit7
// [R14] hot temperature bit, mode from mask2 bit6
// [R15] board temperature alert sets status bit1
// [R16] tach limits set status bits 2, 3
// [R17] intrusion gone high sets status bit4
// [R18] overtemp bit, mode from mask2 bit7
// [R19] mask1 bit one excludes status bit
// [R20] reading a status register clears it
// [R21] mask2 masks thermal status bits 0-5
// [R22] default mode sets each conversion while hot
// [R23] pin active: enabled, unsuppressed, unmasked bit set
// [R24] status2 bits 6, 7 read zero
`timescale 1ns/1ps
`default_nettype none
module mcis_top #(
    parameter int PULSE_CYCLES = mcis_pkg::PULSE_CYCLES
) (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    // register port behind the serial interface
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // fan divisor / reset-output enables from register 05h
    input  wire logic       rst_out_en_i,
    input  wire logic       overtemp_alert_en_i,
    // events from the monitoring loop, same clock
    input  wire logic       conversion_done_i,
    input  wire logic [6:0] voltage_ch_evt_i,
    input  wire logic       tach_one_evt_i,
    input  wire logic       tach_two_evt_i,
    input  wire logic       hot_temp_over_i,
    input  wire logic       overtemp_over_i,
    // asynchronous pins
    input  wire logic       ext_int_n_i,
    input  wire logic       board_temp_alert_input_n_i,
    input  wire logic       intrusion_input_i,
    // monitoring control
    output logic            monitor_run_o,
    output logic            soft_defaults_o,
    output logic            intrusion_latched_o,
    // interrupt pin
    output logic            int_o,
    output logic            int_oe_o,
    // general drive pin, open drain
    output logic            general_drive_pin_o,
    output logic            general_drive_pin_oe_o,
    // reset output pin, open drain
    output logic            rst_out_o,
    output logic            rst_out_oe_o
);

    localparam logic [mcis_pkg::CNT_W-1:0] PULSE_LAST =
        (mcis_pkg::CNT_W)'(PULSE_CYCLES - 1);

    logic ext_int_n;
    logic board_alert_n;
    logic intrusion;

    mcis_sync #(.RST_VAL(1'b1)) u_sync_ext (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .pin_i    (ext_int_n_i),
        .level_o  (ext_int_n)
    );

    mcis_sync #(.RST_VAL(1'b1)) u_sync_board (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .pin_i    (board_temp_alert_input_n_i),
        .level_o  (board_alert_n)
    );

    mcis_sync #(.RST_VAL(1'b0)) u_sync_intrude (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .pin_i    (intrusion_input_i),
        .level_o  (intrusion)
    );

    // register state
    logic [7:0]                cfg_reg,      cfg_next;
    logic [7:0]                vstat_reg,    vstat_next;
    logic [7:0]                tstat_reg,    tstat_next;
    logic [7:0]                vmask_reg,    vmask_next;
    logic [7:0]                tmask_reg,    tmask_next;
    logic [7:0]                rdata_reg,    rdata_next;
    // timers and event memory
    logic [mcis_pkg::CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
    logic [mcis_pkg::CNT_W-1:0] clr_cnt_reg, clr_cnt_next;
    logic                      rst_act_reg,  rst_act_next;
    logic                      latch_reg,    latch_next;
    logic                      hot_armed_reg, hot_armed_next;
    logic                      ot_armed_reg,  ot_armed_next;
    logic                      soft_reg,     soft_next;
    logic                      int_act_reg,  int_act_next;

    logic                      running;
    logic                      wr_cfg;
    logic [7:0]                vset;
    logic [7:0]                tset;
    logic                      pending;

    always_comb begin
        running = cfg_reg[mcis_pkg::CFG_START] & ~cfg_reg[mcis_pkg::CFG_SUPPRESS]; // R01 R06
        wr_cfg  = reg_wr_i && (reg_addr_i == mcis_pkg::CFG_ADDR);

        cfg_next      = cfg_reg;
        vstat_next    = vstat_reg;
        tstat_next    = tstat_reg;
        vmask_next    = vmask_reg;
        tmask_next    = tmask_reg;
        rdata_next    = rdata_reg;
        rst_cnt_next  = rst_cnt_reg;
        clr_cnt_next  = clr_cnt_reg;
        rst_act_next  = rst_act_reg;
        latch_next    = latch_reg;
        hot_armed_next = hot_armed_reg;
        ot_armed_next  = ot_armed_reg;
        soft_next     = 1'b0;
        vset          = 8'h00;
        tset          = 8'h00;

        // chassis clear empties the latch; a live intrusion wins
        if (cfg_reg[mcis_pkg::CFG_CHCLEAR]) begin
            latch_next = 1'b0; // R08
        end
        if (intrusion) begin
            latch_next = 1'b1;
        end

        // monitoring-loop events only while running
        if (running) begin
            vset[6:0] = voltage_ch_evt_i; // R12
            tset[mcis_pkg::TS_TACH1] = tach_one_evt_i; // R16
            tset[mcis_pkg::TS_TACH2] = tach_two_evt_i; // R16
            if (conversion_done_i) begin
                if (!hot_temp_over_i) begin
                    hot_armed_next = 1'b1;
                end else if (!tmask_reg[mcis_pkg::TM_HOT_MODE] || hot_armed_reg) begin
                    tset[mcis_pkg::TS_HOT] = 1'b1; // R14 R22
                    hot_armed_next = 1'b0;
                end
                if (!overtemp_over_i) begin
                    ot_armed_next = 1'b1;
                end else if (!tmask_reg[mcis_pkg::TM_OT_MODE] || ot_armed_reg) begin
                    tset[mcis_pkg::TS_OVERTEMP] = 1'b1; // R18 R22
                    ot_armed_next = 1'b0;
                end
            end
        end
        vset[mcis_pkg::VS_EXTINT]   = ~ext_int_n; // R13
        tset[mcis_pkg::TS_BOARD]    = ~board_alert_n; // R15
        tset[mcis_pkg::TS_INTRUDE]  = latch_next & ~latch_reg; // R17

        // register reads; status clears on read, new events win
        if (reg_rd_i) begin
            case (reg_addr_i)
                mcis_pkg::CFG_ADDR: begin
                    rdata_next = cfg_reg;
                end
                mcis_pkg::VSTAT_ADDR: begin
                    rdata_next = vstat_reg;
                    vstat_next = 8'h00; // R20
                end
                mcis_pkg::TSTAT_ADDR: begin
                    rdata_next = tstat_reg & mcis_pkg::TSTAT_USED; // R24
                    tstat_next = 8'h00; // R20
                end
                mcis_pkg::VMASK_ADDR: begin
                    rdata_next = vmask_reg;
                end
                mcis_pkg::TMASK_ADDR: begin
                    rdata_next = tmask_reg;
                end
                default: begin
                    rdata_next = mcis_pkg::UNMAPPED_RDATA;
                end
            endcase
        end
        vstat_next = vstat_next | vset;
        tstat_next = (tstat_next | tset) & mcis_pkg::TSTAT_USED; // R24

        // register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                mcis_pkg::CFG_ADDR: begin
                    cfg_next = reg_wdata_i; // R01 R02 R04 R05 R06 R09
                end
                mcis_pkg::VMASK_ADDR: begin
                    vmask_next = reg_wdata_i; // R19
                end
                mcis_pkg::TMASK_ADDR: begin
                    tmask_next = reg_wdata_i; // R21
                end
                default: begin
                    cfg_next = cfg_reg;
                end
            endcase
        end

        // reset pulse: starts on a written one only with rst_out_en_i set and overtemp_alert_en_i clear, bit clears when pulse ends
        if (wr_cfg && reg_wdata_i[mcis_pkg::CFG_RSTPULSE] && !rst_act_reg) begin
            if (rst_out_en_i && !overtemp_alert_en_i) begin
                rst_act_next = 1'b1; // R07
                rst_cnt_next = '0;
            end else begin
                cfg_next[mcis_pkg::CFG_RSTPULSE] = 1'b0;
            end
        end else if (rst_act_reg) begin
            cfg_next[mcis_pkg::CFG_RSTPULSE] = 1'b1;
            if (rst_cnt_reg == PULSE_LAST) begin
                rst_act_next = 1'b0; // R07
                cfg_next[mcis_pkg::CFG_RSTPULSE] = 1'b0;
            end else begin
                rst_cnt_next = rst_cnt_reg + 1'b1;
            end
        end

        // chassis clear self-clears after its interval
        if (wr_cfg && reg_wdata_i[mcis_pkg::CFG_CHCLEAR] && !cfg_reg[mcis_pkg::CFG_CHCLEAR]) begin
            clr_cnt_next = '0;
        end else if (cfg_reg[mcis_pkg::CFG_CHCLEAR]) begin
            if (clr_cnt_reg == PULSE_LAST) begin
                cfg_next[mcis_pkg::CFG_CHCLEAR] = 1'b0; // R08
            end else begin
                clr_cnt_next = clr_cnt_reg + 1'b1;
            end
        end

        // soft defaults: whole register set back to reset values
        if (wr_cfg && reg_wdata_i[mcis_pkg::CFG_SOFTDEF]) begin
            soft_next      = 1'b1; // R10
            cfg_next       = mcis_pkg::CFG_RST; // R11
            vstat_next     = mcis_pkg::VSTAT_RST;
            tstat_next     = mcis_pkg::TSTAT_RST;
            vmask_next     = mcis_pkg::VMASK_RST;
            tmask_next     = mcis_pkg::TMASK_RST;
            rst_act_next   = 1'b0;
            rst_cnt_next   = '0;
            clr_cnt_next   = '0;
            hot_armed_next = 1'b1;
            ot_armed_next  = 1'b1;
        end
        cfg_next[mcis_pkg::CFG_SOFTDEF] = 1'b0; // R10

        // pin follows unmasked status; start bit plays no part
        pending = |(vstat_next & ~vmask_next) |
                  |(tstat_next & ~tmask_next & mcis_pkg::TSTAT_USED); // R19 R21 R24 R02
        int_act_next = cfg_next[mcis_pkg::CFG_INT_EN] &
                       ~cfg_next[mcis_pkg::CFG_SUPPRESS] & pending; // R04 R06 R23 R20
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cfg_reg       <= mcis_pkg::CFG_RST; // R11
            vstat_reg     <= mcis_pkg::VSTAT_RST;
            tstat_reg     <= mcis_pkg::TSTAT_RST;
            vmask_reg     <= mcis_pkg::VMASK_RST; // R19
            tmask_reg     <= mcis_pkg::TMASK_RST;
            rdata_reg     <= 8'h00;
            rst_cnt_reg   <= '0;
            clr_cnt_reg   <= '0;
            rst_act_reg   <= 1'b0;
            latch_reg     <= 1'b0;
            hot_armed_reg <= 1'b1;
            ot_armed_reg  <= 1'b1;
            soft_reg      <= 1'b0;
            int_act_reg   <= 1'b0;
        end else begin
            cfg_reg       <= cfg_next;
            vstat_reg     <= vstat_next;
            tstat_reg     <= tstat_next;
            vmask_reg     <= vmask_next;
            tmask_reg     <= tmask_next;
            rdata_reg     <= rdata_next;
            rst_cnt_reg   <= rst_cnt_next;
            clr_cnt_reg   <= clr_cnt_next;
            rst_act_reg   <= rst_act_next;
            latch_reg     <= latch_next;
            hot_armed_reg <= hot_armed_next;
            ot_armed_reg  <= ot_armed_next;
            soft_reg      <= soft_next;
            int_act_reg   <= int_act_next;
        end
    end

    // outputs
    assign reg_rdata_o            = rdata_reg;
    assign monitor_run_o          = cfg_reg[mcis_pkg::CFG_START] &
                                    ~cfg_reg[mcis_pkg::CFG_SUPPRESS]; // R01 R06
    assign soft_defaults_o        = soft_reg;
    assign intrusion_latched_o    = latch_reg;
    assign int_o                  = cfg_reg[mcis_pkg::CFG_INT_POL]; // R05
    assign int_oe_o               = int_act_reg; // R04 R05
    assign general_drive_pin_o    = 1'b0;
    assign general_drive_pin_oe_o = cfg_reg[mcis_pkg::CFG_GPDRIVE]; // R09
    assign rst_out_o              = 1'b0;
    assign rst_out_oe_o           = rst_act_reg; // R07

endmodule
`default_nettype wire

// >>> verif/mcis_props.sv
// port-level assertions for the monitor configuration and interrupt block
`timescale 1ns/1ps
`default_nettype none
module mcis_props #(
    parameter int PULSE_CYCLES = 8
) (
    // clock and reset
    input wire logic       clock_i,
    input wire logic       resetn_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // register 05h enables
    input wire logic       rst_out_en_i,
    input wire logic       overtemp_alert_en_i,
    // observed outputs
    input wire logic       monitor_run_o,
    input wire logic       soft_defaults_o,
    input wire logic       int_o,
    input wire logic       int_oe_o,
    input wire logic       general_drive_pin_o,
    input wire logic       general_drive_pin_oe_o,
    input wire logic       rst_out_o,
    input wire logic       rst_out_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    // shadow of the plain configuration bits, and reset pulse length
    logic [7:0]  cfg_reg;
    logic [7:0]  cfg_next;
    logic [31:0] high_reg;
    logic [31:0] high_next;
    always_comb begin
        cfg_next  = cfg_reg;
        high_next = rst_out_oe_o ? high_reg + 32'h1 : 32'h0;
        if (!resetn_i) begin
            cfg_next  = mcis_pkg::CFG_RST;
            high_next = 32'h0;
        end else if (reg_wr_i && reg_addr_i == mcis_pkg::CFG_ADDR) begin
            cfg_next = reg_wdata_i[7] ? mcis_pkg::CFG_RST : reg_wdata_i;
        end
    end
    always_ff @(posedge clock_i) begin
        cfg_reg  <= cfg_next;
        high_reg <= high_next;
    end

    sequence pulse_req_s;
        reg_wr_i && reg_addr_i == mcis_pkg::CFG_ADDR && reg_wdata_i[4] && !reg_wdata_i[7]
            && rst_out_en_i && !overtemp_alert_en_i && !rst_out_oe_o;
    endsequence
    sequence soft_req_s;
        reg_wr_i && reg_addr_i == mcis_pkg::CFG_ADDR && reg_wdata_i[7];
    endsequence

    pulse_start_a: assert property (pulse_req_s |=> rst_out_oe_o && !rst_out_o)
        else $error("reset pulse did not start");
    pulse_len_a: assert property ($fell(rst_out_oe_o) |-> high_reg == 32'(PULSE_CYCLES))
        else $error("reset pulse length wrong");
    soft_pulse_a: assert property (soft_req_s |=> soft_defaults_o ##1 !soft_defaults_o)
        else $error("soft default pulse wrong");
    run_level_a: assert property (monitor_run_o == (cfg_reg[0] && !cfg_reg[3]))
        else $error("monitor run level wrong");
    int_gate_a: assert property (!cfg_reg[1] || cfg_reg[3] |-> !int_oe_o)
        else $error("interrupt pin driven while disabled");
    int_pol_a: assert property (int_oe_o |-> int_o == cfg_reg[2])
        else $error("interrupt drive level wrong");
    gpo_drive_a: assert property (general_drive_pin_oe_o == cfg_reg[6] && !general_drive_pin_o)
        else $error("general pin drive wrong");
    start_keep_a: assert property (reg_wr_i && reg_addr_i == mcis_pkg::CFG_ADDR && int_oe_o
        && reg_wdata_i[1] && !reg_wdata_i[3] && !reg_wdata_i[7] && !reg_rd_i |=> int_oe_o)
        else $error("interrupt pin dropped by config write");
    rsvd_zero_a: assert property (reg_rd_i && reg_addr_i == mcis_pkg::TSTAT_ADDR
        |=> reg_rdata_o[7:6] == 2'b00)
        else $error("reserved status bits set");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without read");
endmodule

bind mcis_top mcis_props #(.PULSE_CYCLES(PULSE_CYCLES)) props_u (.*);
`default_nettype wire

// >>> verif/mcis_host.sv
// register-port host model, one-cycle strobes, released lines scrambled
`timescale 1ns/1ps
`default_nettype none
module mcis_host (
    // clock
    input  wire logic       clock_i,
    // register port
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_wdata_o,
    // read data valid in this cycle
    output logic            rvalid_o
);
    logic rv = 1'b0;
    assign rvalid_o = rv;
    initial begin
        reg_addr_o  = 8'hA5;
        reg_wdata_o = 8'h5A;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end
    always @(posedge clock_i) rv <= reg_rd_o;

    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = wr;
        reg_rd_o    = !wr;
        @(posedge clock_i);
        #1;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask
endmodule
`default_nettype wire

// >>> verif/mcis_top_tb.sv
// self-checking bench for the monitor configuration and interrupt block
`timescale 1ns/1ps
`default_nettype none
module mcis_top_tb;
    localparam int PULSE = 8;
    logic clock_i = 1'b0, resetn_i = 1'b0, reg_wr_i, reg_rd_i, rvalid;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v, b;
    logic rst_out_en_i = 0, overtemp_alert_en_i = 0, conversion_done_i = 0;
    logic tach_one_evt_i = 0, tach_two_evt_i = 0, hot_temp_over_i = 0, overtemp_over_i = 0;
    logic [6:0] voltage_ch_evt_i = 7'h00;
    logic ext_int_n_i = 1, board_temp_alert_input_n_i = 1, intrusion_input_i = 0;
    logic monitor_run_o, soft_defaults_o, intrusion_latched_o, int_o, int_oe_o;
    logic general_drive_pin_o, general_drive_pin_oe_o, rst_out_o, rst_out_oe_o;
    int bad_count = 0, total_checks = 0, i;
    logic [7:0] exp_q[$];

    always #25 clock_i = ~clock_i;

    mcis_top #(.PULSE_CYCLES(PULSE)) dut_u (.clock_i, .resetn_i, .reg_addr_i, .reg_wr_i,
        .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .rst_out_en_i, .overtemp_alert_en_i,
        .conversion_done_i, .voltage_ch_evt_i, .tach_one_evt_i, .tach_two_evt_i,
        .hot_temp_over_i, .overtemp_over_i, .ext_int_n_i, .board_temp_alert_input_n_i,
        .intrusion_input_i, .monitor_run_o, .soft_defaults_o, .intrusion_latched_o, .int_o,
        .int_oe_o, .general_drive_pin_o, .general_drive_pin_oe_o, .rst_out_o, .rst_out_oe_o);
    mcis_host host_u (.clock_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .rvalid_o(rvalid));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bit_chk(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.access(1'b0, a, 8'h00);
    endtask
    task automatic evt(input logic [6:0] e);
        voltage_ch_evt_i = e;
        step(1);
        voltage_ch_evt_i = 7'h00;
        step(1);
    endtask
    task automatic conv(input int k, input logic over);
        hot_temp_over_i   = (k == 0) && over;
        overtemp_over_i   = (k == 1) && over;
        conversion_done_i = 1'b1;
        step(1);
        conversion_done_i = 1'b0;
        step(1);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // read data is registered on the read edge and checked at the next falling edge
    always @(negedge clock_i) begin
        if (rvalid === 1'b1) begin
            chk(reg_rdata_o, exp_q.pop_front());
        end
    end

    initial begin
        void'($urandom(32'h40680b16));
        step(5);
        resetn_i = 1'b1;
        rd(8'h00, 8'h08);
        for (int a = 1; a < 5; a++) rd(8'(a), 8'h00);
        rd(8'h07, 8'h00);
        v = 8'($urandom());
        wr(8'h03, v);
        rd(8'h03, v);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h00);
        wr(8'h03, 8'h00);
        wr(8'h00, 8'h03);
        v = {1'b0, 7'($urandom())} | 8'h01;
        evt(v[6:0]);
        bit_chk(int_oe_o, 1'b1);
        bit_chk(int_o, 1'b0);
        wr(8'h00, 8'h02);
        bit_chk(int_oe_o, 1'b1);
        wr(8'h00, 8'h0A);
        bit_chk(int_oe_o, 1'b0);
        bit_chk(monitor_run_o, 1'b0);
        wr(8'h00, 8'h02);
        bit_chk(int_oe_o, 1'b1);
        rd(8'h01, v);
        bit_chk(int_oe_o, 1'b0);
        evt(7'h7F);
        rd(8'h01, 8'h00);
        wr(8'h00, 8'h03);
        wr(8'h03, 8'hFF);
        evt(v[6:0]);
        bit_chk(int_oe_o, 1'b0);
        rd(8'h01, v);
        wr(8'h03, 8'h00);
        ext_int_n_i = 1'b0;
        step(4);
        ext_int_n_i = 1'b1;
        board_temp_alert_input_n_i = 1'b0;
        tach_one_evt_i = 1'b1;
        step(1);
        tach_one_evt_i = 1'b0;
        tach_two_evt_i = 1'b1;
        step(3);
        tach_two_evt_i = 1'b0;
        board_temp_alert_input_n_i = 1'b1;
        step(6);
        rd(8'h01, 8'h80);
        rd(8'h02, 8'h0E);
        intrusion_input_i = 1'b1;
        step(6);
        bit_chk(intrusion_latched_o, 1'b1);
        rd(8'h02, 8'h10);
        intrusion_input_i = 1'b0;
        wr(8'h00, 8'h23);
        step(4);
        bit_chk(intrusion_latched_o, 1'b0);
        step(PULSE + 2);
        rd(8'h00, 8'h03);
        for (int k = 0; k < 2; k++) begin
            b = k ? 8'h20 : 8'h01;
            wr(8'h04, 8'h00);
            conv(k, 1'b1);
            bit_chk(int_oe_o, 1'b1);
            rd(8'h02, b);
            conv(k, 1'b1);
            rd(8'h02, b);
            wr(8'h04, b);
            conv(k, 1'b1);
            bit_chk(int_oe_o, 1'b0);
            rd(8'h02, b);
            conv(k, 1'b0);
            wr(8'h04, k ? 8'h80 : 8'h40);
            conv(k, 1'b1);
            rd(8'h02, b);
            conv(k, 1'b1);
            rd(8'h02, 8'h00);
            conv(k, 1'b0);
        end
        wr(8'h04, 8'h00);
        rst_out_en_i = 1'b1;
        wr(8'h00, 8'h13);
        bit_chk(rst_out_oe_o, 1'b1);
        bit_chk(rst_out_o, 1'b0);
        rd(8'h00, 8'h13);
        for (i = 0; i < 100 && rst_out_oe_o === 1'b1; i++) step(1);
        if (i == 100) begin
            bad_count++;
            $display("FAIL %0t reset pulse never ended", $time);
            results();
        end
        rd(8'h00, 8'h03);
        overtemp_alert_en_i = 1'b1;
        wr(8'h00, 8'h13);
        bit_chk(rst_out_oe_o, 1'b0);
        rd(8'h00, 8'h03);
        wr(8'h00, 8'h47);
        bit_chk(general_drive_pin_oe_o, 1'b1);
        evt(v[6:0]);
        bit_chk(int_o, 1'b1);
        bit_chk(int_oe_o, 1'b1);
        bit_chk(general_drive_pin_o, 1'b0);
        wr(8'h03, 8'h5A);
        wr(8'h00, 8'h80);
        rd(8'h00, 8'h08);
        rd(8'h03, 8'h00);
        rd(8'h01, 8'h00);
        resetn_i = 1'b0;
        step(5);
        resetn_i = 1'b1;
        rd(8'h00, 8'h08);
        step(3);
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("FAIL %0t reads left unanswered", $time);
        end
        results();
    end
endmodule
`default_nettype wire
